/* File: elp_map.svh */
/*
 * Offsets, field positions, counts and codes of the exception
 * and low-power controller. Assumes a 32-bit APB with byte addresses.
 */
// Operation
// - Finish current instruction before interrupt processing.
// - Take interrupt only if unmasked and enabled.
// - Highest-priority pending interrupt is served first.
// - Pending interrupt after return served before program.
// - Interrupt stacking leaves high index register out.
// - Software interrupt instruction ignores the mask.
// - Software pushes PC, hardware pushes PC minus one.
// - Reset overrides every interrupt, never arbitrated.
// - Break blocks flag clearing unless clear enable set.
// - Flag cleared during break stays cleared afterwards.
// - Two-step flags stay protected; clear after break. Here clear enable unblocks them too.
// - Wait and stop instructions clear interrupt mask.
// - Wait stops processor clocks, peripherals keep running.
// - Wait wake-up stacks one cycle after interrupt.
// - Reset or break ends wait; break sets exit flag.
// - Watchdog runs in wait unless disabled.
// - Stop resets counter and disables both clock outputs.
// - Stop ends on interrupt, reset, break; delayed stacking.
// - Recovery 4096 crystal cycles, or 32 when short.
// - Break ending stop sets the exit flag.
// - Counter held cleared in stop until recovery.
// - Twelve-bit counter on crystal clock falling edge.
// - Latched interrupt cannot be pre-empted before service.
// - Entry saves registers and sets interrupt mask.
// - Exit flag cleared by writing zero or reset.
`ifndef ELP_MAP_SVH
`define ELP_MAP_SVH

// --------------------------------------------------------------------
// Register offsets.
// --------------------------------------------------------------------
`define ELP_ADDR_BSR 8'h00
`define ELP_ADDR_BFCR 8'h04
`define ELP_ADDR_OPT 8'h08
`define ELP_ADDR_STAT 8'h0c

// --------------------------------------------------------------------
// Field positions.
// --------------------------------------------------------------------
`define ELP_BIT_EXIT 0
`define ELP_BIT_BREAK_FLAG_CLEAR_ENABLE 0
`define ELP_BIT_SHORT 0
`define ELP_BIT_WDDIS 1

// --------------------------------------------------------------------
// Counts and codes.
// --------------------------------------------------------------------
`define ELP_NSRC 8
`define ELP_VEC_SWI 4'h0
`define ELP_REC_LONG 12'hfff
`define ELP_REC_SHORT 12'h01f
`define ELP_CNT_ZERO 12'h000
`define ELP_CNT_ONE 12'h001

`endif

/* File: elp_pkg.sv */
/*
 * Types shared by the exception and low-power controller.
 * Assumes elp_map.svh supplies the numeric constants.
 */
package elp_pkg;

    // Controller states, Gray coded along run, entry, wait, stop, recovery.
    typedef enum logic [2:0] {
        ELP_RUN = 3'h0,
        ELP_ENTRY = 3'h1,
        ELP_WAIT = 3'h3,
        ELP_STOP = 3'h2,
        ELP_RECOV = 3'h6
    } elp_state_t;

    // Software configuration bits.
    typedef struct packed {
        logic break_flag_clear_enable;
        logic short_recovery_select;
        logic watchdog_disable;
    } elp_cfg_t;

endpackage

/* File: elp_recovery_counter.sv */
/*
 * Twelve-bit stop recovery counter advanced on falling crystal edges.
 * Assumes the crystal clock is a synchronous input, slower than i_clk.
 */
`timescale 1ns/1ps
`include "elp_map.svh"

module elp_recovery_counter (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control.
    input wire logic i_clear,
    input wire logic i_crystal_clock,
    input wire logic i_short,
    // Result.
    output logic o_done
);

    logic [11:0] count; // Crystal cycles elapsed since the wake event.
    logic xtal_q; // Crystal level one clock earlier.
    logic fall; // A falling crystal edge was seen.
    logic [11:0] term; // Selected terminal count.

    // ----------------------------------------------------------------
    // Edge detect and terminal select.
    // ----------------------------------------------------------------

    // The crystal is sampled, so it must be well below half of i_clk.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= i_crystal_clock;
        end
    end

    assign fall = xtal_q & ~i_crystal_clock;
    assign term = i_short ? `ELP_REC_SHORT : `ELP_REC_LONG;

    // ----------------------------------------------------------------
    // Counter.
    // ----------------------------------------------------------------

    // Held at zero while cleared, then counts until the terminal value.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            count <= `ELP_CNT_ZERO;
            o_done <= 1'b0;
        end else if (fall && !o_done) begin
            count <= count + `ELP_CNT_ONE;
            o_done <= (count == term);
        end
    end

endmodule // elp_recovery_counter

/* File: elp_exception_ctrl.sv */
/*
 * Exception sequencing and low-power control for an 8-bit core:
 * interrupt arbitration at instruction boundaries, break entry, flag
 * protection in break, wait and stop with timed stop recovery.
 * Assumes the core reports instruction completion, executed special
 * instructions, its mask bit and the end of stacking, all synchronous.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "elp_map.svh"

module elp_exception_ctrl (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // Core status.
    input wire logic i_instr_done,
    input wire logic i_imask,
    input wire logic i_swi_exec,
    input wire logic i_wait_exec,
    input wire logic i_stop_exec,
    input wire logic i_stack_done,
    input wire logic i_break_rti,
    // Event sources.
    input wire logic [`ELP_NSRC-1:0] i_irq_req,
    input wire logic [`ELP_NSRC-1:0] i_irq_en,
    input wire logic i_break_req,
    input wire logic i_sys_reset,
    input wire logic i_crystal_clock,
    // Core control.
    output logic o_int_start,
    output logic [3:0] o_vector_sel,
    output logic o_push_pc_minus1,
    output logic o_stack_h,
    output logic o_set_imask,
    output logic o_clr_imask,
    // Clock gating and system.
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_base_clk_en,
    output logic o_xtal_clk_en,
    output logic o_watchdog_run,
    output logic o_break_state,
    output logic o_flag_clear_allow,
    output logic o_break_exit_flag
);

    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    elp_pkg::elp_state_t state; // Current controller state.
    elp_pkg::elp_state_t next_state; // State for the next edge.
    elp_pkg::elp_cfg_t cfg; // Software configuration.
    logic [`ELP_NSRC-1:0] pend; // Requests that are also enabled.
    logic [3:0] next_vec; // Vector chosen for a new entry.
    logic next_minus1; // Push PC minus one for a new entry.
    logic next_brk; // The new entry is a break.
    logic next_exit; // Break ends wait or stop this cycle.
    logic next_clr; // Wait or stop instruction taken.
    logic wake_brk; // Stop was left by a break.
    logic rec_done; // Recovery count finished.
    logic setup; // APB setup phase.
    logic wr_ok; // APB write takes effect.

    // Lowest index wins; zero means nothing pending.
    function automatic logic [3:0] pick(input logic [`ELP_NSRC-1:0] p);
        logic [3:0] r;
        r = `ELP_VEC_SWI;
        for (int i = `ELP_NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    assign pend = i_irq_req & i_irq_en;
    assign setup = i_psel & ~i_penable;
    assign wr_ok = i_psel & i_penable & o_pready & i_pwrite;

    // ----------------------------------------------------------------
    // Sequencer.
    // ----------------------------------------------------------------

    // Decisions in run happen only at instruction completion, so a running
    // instruction is never cut short by a hardware request.
    always_comb begin
        next_state = state;
        next_vec = o_vector_sel;
        next_minus1 = o_push_pc_minus1;
        next_brk = 1'b0;
        next_exit = 1'b0;
        next_clr = 1'b0;
        case (state)
            elp_pkg::ELP_RUN: begin
                if (i_instr_done) begin
                    if (i_break_req) begin
                        next_state = elp_pkg::ELP_ENTRY;
                        next_vec = `ELP_VEC_SWI;
                        next_minus1 = 1'b0;
                        next_brk = 1'b1;
                    end else if (i_swi_exec) begin
                        next_state = elp_pkg::ELP_ENTRY;
                        next_vec = `ELP_VEC_SWI;
                        next_minus1 = 1'b0;
                    end else if (!i_imask && (pend != '0)) begin
                        // A return is itself a boundary, so a request
                        // left pending is taken before the next opcode.
                        next_state = elp_pkg::ELP_ENTRY;
                        next_vec = pick(pend);
                        next_minus1 = 1'b1;
                    end else if (i_wait_exec) begin
                        next_state = elp_pkg::ELP_WAIT;
                        next_clr = 1'b1;
                    end else if (i_stop_exec) begin
                        next_state = elp_pkg::ELP_STOP;
                        next_clr = 1'b1;
                    end
                end
            end
            elp_pkg::ELP_ENTRY: begin
                // The latched vector is held until stacking ends.
                if (i_stack_done) begin
                    next_state = elp_pkg::ELP_RUN;
                end
            end
            elp_pkg::ELP_WAIT: begin
                if (i_break_req) begin
                    next_state = elp_pkg::ELP_ENTRY;
                    next_vec = `ELP_VEC_SWI;
                    next_minus1 = 1'b0;
                    next_brk = 1'b1;
                    next_exit = 1'b1;
                end else if (pend != '0) begin
                    next_state = elp_pkg::ELP_ENTRY;
                    next_vec = pick(pend);
                    next_minus1 = 1'b1;
                end
            end
            elp_pkg::ELP_STOP: begin
                if (i_break_req || (pend != '0)) begin
                    next_state = elp_pkg::ELP_RECOV;
                    next_exit = i_break_req;
                end
            end
            elp_pkg::ELP_RECOV: begin
                // Stacking waits for the full recovery period.
                if (rec_done) begin
                    if (wake_brk) begin
                        next_state = elp_pkg::ELP_ENTRY;
                        next_vec = `ELP_VEC_SWI;
                        next_minus1 = 1'b0;
                        next_brk = 1'b1;
                    end else if (pend != '0) begin
                        next_state = elp_pkg::ELP_ENTRY;
                        next_vec = pick(pend);
                        next_minus1 = 1'b1;
                    end else begin
                        next_state = elp_pkg::ELP_RUN;
                    end
                end
            end
            default: begin
                next_state = elp_pkg::ELP_RUN;
            end
        endcase
    end

    // State, latched vector and entry strobes; any reset source wins.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            state <= elp_pkg::ELP_RUN;
            o_vector_sel <= `ELP_VEC_SWI;
            o_push_pc_minus1 <= 1'b0;
            o_int_start <= 1'b0;
            o_set_imask <= 1'b0;
            o_clr_imask <= 1'b0;
        end else begin
            state <= next_state;
            o_vector_sel <= next_vec;
            o_push_pc_minus1 <= next_minus1;
            o_int_start <= (next_state == elp_pkg::ELP_ENTRY) &&
                           (state != elp_pkg::ELP_ENTRY);
            o_set_imask <= (next_state == elp_pkg::ELP_ENTRY) &&
                           (state != elp_pkg::ELP_ENTRY);
            o_clr_imask <= next_clr;
        end
    end

    // The high index register is never stacked by hardware.
    always_ff @(posedge i_clk) begin
        o_stack_h <= 1'b0;
    end

    // Remember whether stop was left by a break.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            wake_brk <= 1'b0;
        end else if (state == elp_pkg::ELP_STOP) begin
            wake_brk <= i_break_req;
        end
    end

    // ----------------------------------------------------------------
    // Clock gating and watchdog.
    // ----------------------------------------------------------------

    // Gates follow the next state so they line up with the state flop.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            o_cpu_clk_en <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_base_clk_en <= 1'b1;
            o_xtal_clk_en <= 1'b1;
            o_watchdog_run <= 1'b0;
        end else begin
            o_cpu_clk_en <= (next_state == elp_pkg::ELP_RUN) ||
                            (next_state == elp_pkg::ELP_ENTRY);
            o_periph_clk_en <= (next_state != elp_pkg::ELP_STOP) &&
                               (next_state != elp_pkg::ELP_RECOV);
            o_base_clk_en <= (next_state != elp_pkg::ELP_STOP) &&
                             (next_state != elp_pkg::ELP_RECOV);
            o_xtal_clk_en <= (next_state != elp_pkg::ELP_STOP) &&
                             (next_state != elp_pkg::ELP_RECOV);
            // Still counting in wait; halted with the clocks in stop.
            o_watchdog_run <= !cfg.watchdog_disable &&
                              (o_cpu_clk_en || o_periph_clk_en);
        end
    end

    // ----------------------------------------------------------------
    // Stop recovery counter.
    // ----------------------------------------------------------------
    elp_recovery_counter u_rec (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(state != elp_pkg::ELP_RECOV),
        .i_crystal_clock(i_crystal_clock),
        .i_short(cfg.short_recovery_select),
        .o_done(rec_done)
    );

    // ----------------------------------------------------------------
    // Break state and flag protection.
    // ----------------------------------------------------------------

    // Break state lasts from break entry to the return from its routine.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            o_break_state <= 1'b0;
        end else if (next_brk) begin
            o_break_state <= 1'b1;
        end else if (i_break_rti) begin
            o_break_state <= 1'b0;
        end
    end

    // Peripherals only clear flags, or finish a two-step clear, while
    // this is high; a flag cleared here is simply not set again.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            o_flag_clear_allow <= 1'b1;
        end else begin
            o_flag_clear_allow <= !o_break_state || cfg.break_flag_clear_enable;
        end
    end

    // Exit flag: a break setting it beats a write of zero.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_sys_reset) begin
            o_break_exit_flag <= 1'b0;
        end else if (next_exit) begin
            o_break_exit_flag <= 1'b1;
        end else if (wr_ok && (i_paddr == `ELP_ADDR_BSR) &&
                     !i_pwdata[`ELP_BIT_EXIT]) begin
            o_break_exit_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // APB slave.
    // ----------------------------------------------------------------

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready &&
                         (i_paddr != `ELP_ADDR_BSR) && (i_paddr != `ELP_ADDR_BFCR) &&
                         (i_paddr != `ELP_ADDR_OPT) && (i_paddr != `ELP_ADDR_STAT);
        end
    end

    // Configuration writes.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg <= '0;
        end else if (wr_ok && (i_paddr == `ELP_ADDR_BFCR)) begin
            cfg.break_flag_clear_enable <= i_pwdata[`ELP_BIT_BREAK_FLAG_CLEAR_ENABLE];
        end else if (wr_ok && (i_paddr == `ELP_ADDR_OPT)) begin
            cfg.short_recovery_select <= i_pwdata[`ELP_BIT_SHORT];
            cfg.watchdog_disable <= i_pwdata[`ELP_BIT_WDDIS];
        end
    end

    // Read data is captured in setup; unmapped reads return zero.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= '0;
        end else if (setup) begin
            case (i_paddr)
                `ELP_ADDR_BSR: o_prdata <= {31'h0, o_break_exit_flag};
                `ELP_ADDR_BFCR: o_prdata <= {31'h0, cfg.break_flag_clear_enable};
                `ELP_ADDR_OPT: o_prdata <= {30'h0, cfg.watchdog_disable,
                                            cfg.short_recovery_select};
                `ELP_ADDR_STAT: o_prdata <= {24'h0, o_vector_sel,
                                             o_break_state, state};
                default: o_prdata <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_int_boundary: assert property (
        o_int_start && ($past(state) == elp_pkg::ELP_RUN) |-> $past(i_instr_done))
        else $error("entry started off an instruction boundary");
    chk_mask_gate: assert property (
        (state == elp_pkg::ELP_RUN) && i_instr_done && i_imask && !i_swi_exec &&
        !i_break_req |=> !o_int_start)
        else $error("masked hardware request was taken");
    chk_prio_pick: assert property (
        o_int_start && o_push_pc_minus1 && $past(state == elp_pkg::ELP_RUN)
        |-> o_vector_sel == pick($past(pend)))
        else $error("wrong priority chosen");
    chk_swi_unmasked: assert property (
        (state == elp_pkg::ELP_RUN) && i_instr_done && i_swi_exec && !i_break_req &&
        !i_sys_reset |=> o_int_start && (o_vector_sel == `ELP_VEC_SWI))
        else $error("software interrupt not taken");
    chk_hw_minus1: assert property (
        o_int_start && (o_vector_sel != `ELP_VEC_SWI) |-> o_push_pc_minus1)
        else $error("hardware entry must push PC minus one");
    chk_reset_wins: assert property (
        i_sys_reset |=> (state == elp_pkg::ELP_RUN) && !o_int_start)
        else $error("reset did not override");
    chk_latched_hold: assert property (
        (state == elp_pkg::ELP_ENTRY) && !i_stack_done && !i_sys_reset
        |=> $stable(o_vector_sel))
        else $error("latched interrupt was pre-empted");
    chk_clear_block: assert property (
        o_break_state && !cfg.break_flag_clear_enable && !i_sys_reset |=> !o_flag_clear_allow)
        else $error("flag clearing allowed in break");
    chk_wait_clk: assert property (
        (state == elp_pkg::ELP_WAIT) |-> !o_cpu_clk_en && o_periph_clk_en)
        else $error("wrong clocks in wait");
    chk_stop_clk: assert property (
        (state == elp_pkg::ELP_STOP) |-> !o_base_clk_en && !o_xtal_clk_en)
        else $error("clock outputs running in stop");
    chk_stop_flag: assert property (
        (state == elp_pkg::ELP_STOP) && i_break_req && !i_sys_reset
        |=> o_break_exit_flag)
        else $error("break out of stop left flag clear");

    cov_wait_wake: cover property (
        (state == elp_pkg::ELP_WAIT) ##1 (state == elp_pkg::ELP_ENTRY));
    cov_stop_recov: cover property (
        (state == elp_pkg::ELP_RECOV) ##1 (state == elp_pkg::ELP_ENTRY));
    cov_break_entry: cover property (o_int_start && o_break_state);

endmodule // elp_exception_ctrl

/* File: elp_core_model.sv */
/* Core-side partner: ends stacking a set time after each entry.
   Assumes the entry strobe and mask-set strobe are one-cycle pulses. */
`timescale 1ns/1ps
module elp_core_model #(parameter int DELAY = 4) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Controller strobes.
    input wire logic i_int_start,
    input wire logic i_set_imask,
    // Answers.
    output logic o_stack_done,
    output logic [7:0] o_entries
);
    int cnt; // Cycles left until stacking ends.
    // A slow answer keeps entry open so late requests can try to pre-empt.
    always_ff @(posedge i_clk) begin
        o_stack_done <= 1'b0;
        if (!i_rst_n) begin
            cnt <= 0;
            o_entries <= 8'h00;
        end else if (i_int_start && i_set_imask) begin
            cnt <= DELAY;
            o_entries <= o_entries + 8'h01;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_stack_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // elp_core_model

/* File: exception_and_low_power_control_tb.sv */
/* Bench for the exception controller: APB tasks and event sequences.
   Assumes the core model answers entry and the bench plays the sources. */
`timescale 1ns/1ps
`include "elp_map.svh"
module exception_and_low_power_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, psel, pen, pwr, pready, pslverr, e;
    logic idone, imask, software_interrupt_instruction, wt, stp, brti, breq, sysr, xtal, stack_done;
    logic int_start, pm1, sth, seti, clri, cpu_en, per_en, base_en, xt_en;
    logic wd, brk, allow, exitf;
    logic [1:0] xdiv = 2'h0; // Crystal divider: one period per 4 cycles.
    logic [3:0] vec;
    logic [7:0] paddr, irq, en, entries;
    logic [31:0] pwdata, prdata, q;
    int bad_count = 0, samples_checked = 0, cycles = 0, n;
    always #2 clk = ~clk;
    always_ff @(posedge clk) xdiv <= xdiv + 2'h1;
    assign xtal = xdiv[1];
    elp_exception_ctrl DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_instr_done(idone), .i_imask(imask),
        .i_swi_exec(software_interrupt_instruction), .i_wait_exec(wt), .i_stop_exec(stp), .i_stack_done(stack_done),
        .i_break_rti(brti), .i_irq_req(irq), .i_irq_en(en), .i_break_req(breq),
        .i_sys_reset(sysr), .i_crystal_clock(xtal), .o_int_start(int_start),
        .o_vector_sel(vec), .o_push_pc_minus1(pm1), .o_stack_h(sth), .o_set_imask(seti),
        .o_clr_imask(clri), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
        .o_base_clk_en(base_en), .o_xtal_clk_en(xt_en), .o_watchdog_run(wd),
        .o_break_state(brk), .o_flag_clear_allow(allow), .o_break_exit_flag(exitf));
    elp_core_model #(.DELAY(4)) core (.i_clk(clk), .i_rst_n(rst_n), .i_int_start(int_start),
        .i_set_imask(seti), .o_stack_done(stack_done), .o_entries(entries));
    // Reports a mismatch at once and counts every comparison.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin @(posedge clk); end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // One idle edge, so a following call never re-drives psel at once.
        @(posedge clk);
    endtask
    // One instruction boundary; the kind bits ride on the completion pulse.
    task automatic boundary(input logic [2:0] kind);
        idone <= 1'b1;
        {software_interrupt_instruction, wt, stp} <= kind;
        @(posedge clk);
        idone <= 1'b0;
        {software_interrupt_instruction, wt, stp} <= 3'h0;
    endtask
    // Bounded wait for entry, then its vector and pushed-PC kind.
    task automatic entry(input logic [3:0] v, input logic m1);
        n = 0;
        do begin @(posedge clk); n++; end while (int_start !== 1'b1 && n < 300);
        check(seti, 1'b1);
        check(vec, v);
        check(pm1, m1);
        check(sth, 1'b0);
    endtask
    task automatic settle;
        @(posedge clk);
        for (int k = 0; k < 20 && stack_done !== 1'b1; k++) @(posedge clk);
        check(stack_done, 1'b1);
    endtask
    // Hang guard: a run this long means a handshake never came.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 25000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {psel, pen, pwr, idone, imask, software_interrupt_instruction, wt, stp, brti, breq, sysr} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq = 8'h00;
        en = 8'hff;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, `ELP_ADDR_BSR, 32'h0);
        check(q, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({e, q[30:0]}, 32'h80000000);
        // Masked, then unmasked with two sources pending.
        imask <= 1'b1;
        irq <= 8'h24;
        boundary(3'h0);
        repeat (3) @(posedge clk);
        check(entries, 8'h00);
        imask <= 1'b0;
        boundary(3'h0);
        entry(4'h3, 1'b1);
        irq <= 8'h25;
        repeat (2) @(posedge clk);
        check(vec, 4'h3);
        settle();
        boundary(3'h0);
        entry(4'h1, 1'b1);
        settle();
        en <= 8'hfe;
        irq <= 8'h01;
        boundary(3'h0);
        repeat (3) @(posedge clk);
        check(entries, 8'h02);
        irq <= 8'h00;
        en <= 8'hff;
        imask <= 1'b1;
        boundary(3'h4);
        entry(4'h0, 1'b0);
        settle();
        // Wait, then wake by a source.
        boundary(3'h2);
        @(posedge clk);
        check({clri, cpu_en, per_en, wd}, 32'hb);
        irq <= 8'h04;
        entry(4'h3, 1'b1);
        settle();
        irq <= 8'h00;
        // Stop with short recovery; the counter must not run while stopped.
        apb(1'b1, `ELP_ADDR_OPT, 32'h1);
        boundary(3'h1);
        @(posedge clk);
        check({clri, base_en, xt_en, per_en}, 32'h8);
        repeat (40) @(posedge clk);
        irq <= 8'h04;
        entry(4'h3, 1'b1);
        check(n > 120 && n < 140, 1'b1);
        check({base_en, xt_en, per_en}, 32'h7);
        settle();
        irq <= 8'h00;
        // Long recovery with the watchdog disabled; no entry before it ends.
        apb(1'b1, `ELP_ADDR_OPT, 32'h2);
        boundary(3'h1);
        check(wd, 1'b0);
        irq <= 8'h04;
        repeat (16300) @(posedge clk);
        check(entries, 8'h05);
        entry(4'h3, 1'b1);
        check(n < 200, 1'b1);
        settle();
        irq <= 8'h00;
        // Break ends wait; flag protection and exit flag handling.
        boundary(3'h2);
        repeat (2) @(posedge clk);
        breq <= 1'b1;
        entry(4'h0, 1'b0);
        breq <= 1'b0;
        settle();
        @(posedge clk);
        check({brk, allow, exitf}, 32'h5);
        apb(1'b1, `ELP_ADDR_BFCR, 32'h1);
        repeat (2) @(posedge clk);
        check(allow, 1'b1);
        apb(1'b1, `ELP_ADDR_BSR, 32'h0);
        apb(1'b0, `ELP_ADDR_BSR, 32'h0);
        check(q, 32'h0);
        // A system reset beats a pending enabled source.
        irq <= 8'h04;
        imask <= 1'b0;
        sysr <= 1'b1;
        boundary(3'h0);
        sysr <= 1'b0;
        irq <= 8'h00;
        repeat (3) @(posedge clk);
        check(entries, 8'h07);
        print_verdict();
    end
endmodule // exception_and_low_power_control_tb
